// ==== design/phy_evt_pkg.sv ====
// Purpose: constants and carriers for the event status and error counter block
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit byte address
// Notes:   register index times four gives the byte address
package phy_evt_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int unsigned ADDR_W        = 8;
   localparam logic [7:0]  IDX_IRQ_CTRL  = 8'h11;
   localparam logic [7:0]  IDX_EVT_STAT  = 8'h12;
   localparam logic [7:0]  IDX_FC_COUNT  = 8'h14;
   localparam logic [7:0]  IDX_RX_COUNT  = 8'h15;
   localparam logic [7:0]  ADDR_IRQ_CTRL = 8'(IDX_IRQ_CTRL * 4);
   localparam logic [7:0]  ADDR_EVT_STAT = 8'(IDX_EVT_STAT * 4);
   localparam logic [7:0]  ADDR_FC_COUNT = 8'(IDX_FC_COUNT * 4);
   localparam logic [7:0]  ADDR_RX_COUNT = 8'(IDX_RX_COUNT * 4);

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam int unsigned NUM_EVT      = 7;
   localparam int unsigned ST_LSB       = 8;
   localparam int unsigned EN_LSB       = 0;
   localparam int unsigned CTL_OE_BIT   = 0;
   localparam int unsigned CTL_GATE_BIT = 1;
   localparam int unsigned CTL_TEST_BIT = 2;
   localparam int unsigned CNT_HALF_BIT = 7;
   localparam logic [6:0]  RST_STATUS   = 7'h00;
   localparam logic [6:0]  RST_ENABLE   = 7'h00;
   localparam logic [2:0]  RST_CTRL     = 3'h0;
   localparam logic [7:0]  RST_COUNT    = 8'h00;
   localparam logic [7:0]  CNT_MAX      = 8'hFF;
   localparam logic [7:0]  CNT_BELOW_HALF = 8'h7F;

   // event vector positions, same order as status bits 14..8
   localparam int unsigned EV_ED   = 6;
   localparam int unsigned EV_LINK = 5;
   localparam int unsigned EV_SPD  = 4;
   localparam int unsigned EV_DUP  = 3;
   localparam int unsigned EV_ANC  = 2;
   localparam int unsigned EV_FHF  = 1;
   localparam int unsigned EV_RHF  = 0;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;

   typedef struct packed {
      logic energy_detect;
      logic link_change;
      logic speed_change;
      logic duplex_change;
      logic autoneg_done;
      logic false_carrier;
      logic carrier_valid;
      logic symbol_invalid;
      logic collision;
   } phy_evt_t;

endpackage

// ==== design/phy_event_status_and_error_counters.sv ====
// Purpose: event status, enables, interrupt gating and error counters
// Assumes: phy event inputs are produced on SYS_CLK; pin input is async
// Notes:   all status and counters clear when their register is read
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module phy_event_status_and_error_counters
   import phy_evt_pkg::*;
(
   input  wire  logic                   SYS_CLK,
   input  wire  logic                   SRST,
   input  wire  phy_evt_pkg::axil_req_t AXI_REQ,
   output       phy_evt_pkg::axil_rsp_t AXI_RSP,
   input  wire  phy_evt_pkg::phy_evt_t  PHY_EVT,
   input  wire  logic                   PWRDN_IRQ_I,
   output       logic                   PWRDN_IRQ_O,
   output       logic                   PWRDN_IRQ_OE,
   output       logic                   POWER_DOWN
);
   import phy_evt_pkg::*;

   typedef enum logic {WR_COLLECT, WR_RESP} wr_state_t;
   typedef enum logic {RD_IDLE, RD_RESP} rd_state_t;

   wr_state_t          wr_state_q;
   wr_state_t          wr_state_d;
   rd_state_t          rd_state_q;
   rd_state_t          rd_state_d;
   logic               aw_ready_q;
   logic               w_ready_q;
   logic               aw_have_q;
   logic               aw_have_d;
   logic               w_have_q;
   logic               w_have_d;
   logic [ADDR_W-1:0]  awaddr_q;
   logic [31:0]        wdata_q;
   logic [3:0]         wstrb_q;
   logic               bvalid_q;
   logic [1:0]         bresp_q;
   logic               ar_ready_q;
   logic               rvalid_q;
   logic [31:0]        rdata_q;
   logic [1:0]         rresp_q;
   logic [31:0]        rd_mux;
   logic               rd_hit;
   logic               aw_hs;
   logic               w_hs;
   logic               wr_fire;
   logic               rd_fire;
   logic               wr_lane0;

   logic [NUM_EVT-1:0] status_q;
   logic [NUM_EVT-1:0] enable_q;
   logic [NUM_EVT-1:0] evt;
   logic [2:0]         ctrl_q;
   logic [7:0]         fc_q;
   logic [7:0]         rx_q;
   logic               counted_q;
   logic               fc_inc;
   logic               rx_inc;
   logic               fc_half;
   logic               rx_half;
   logic               event_status_and_enable_clr;
   logic               fc_clr;
   logic               rx_clr;
   logic               irq_q;
   logic               oe_q;
   logic               pd_meta_q;
   logic               pd_sync_q;
   logic               pd_q;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   // ****************************************
   // bus handshakes
   // ****************************************
   assign aw_hs    = AXI_REQ.awvalid && aw_ready_q;
   assign w_hs     = AXI_REQ.wvalid && w_ready_q;
   assign wr_fire  = (wr_state_q == WR_COLLECT) && aw_have_q && w_have_q;
   assign rd_fire  = AXI_REQ.arvalid && ar_ready_q;
   assign wr_lane0 = wr_fire && wstrb_q[0];

   always_comb
   begin
      aw_have_d  = (aw_have_q || aw_hs) && !wr_fire;
      w_have_d   = (w_have_q || w_hs) && !wr_fire;
      wr_state_d = wr_state_q;
      case (wr_state_q)
         WR_COLLECT: if (wr_fire) wr_state_d = WR_RESP;
         WR_RESP:    if (AXI_REQ.bready) wr_state_d = WR_COLLECT;
         default:    wr_state_d = WR_COLLECT;
      endcase
      rd_state_d = rd_state_q;
      case (rd_state_q)
         RD_IDLE: if (rd_fire) rd_state_d = RD_RESP;
         RD_RESP: if (AXI_REQ.rready) rd_state_d = RD_IDLE;
         default: rd_state_d = RD_IDLE;
      endcase
   end

   // write channels are taken in either order and answered once both are in
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         wr_state_q <= WR_COLLECT;
         aw_have_q  <= 1'b0;
         w_have_q   <= 1'b0;
         aw_ready_q <= 1'b0;
         w_ready_q  <= 1'b0;
         bvalid_q   <= 1'b0;
         bresp_q    <= RESP_OKAY;
         awaddr_q   <= '0;
         wdata_q    <= '0;
         wstrb_q    <= '0;
      end
      else
      begin
         wr_state_q <= wr_state_d;
         aw_have_q  <= aw_have_d;
         w_have_q   <= w_have_d;
         aw_ready_q <= (wr_state_d == WR_COLLECT) && !aw_have_d;
         w_ready_q  <= (wr_state_d == WR_COLLECT) && !w_have_d;
         bvalid_q   <= (wr_state_d == WR_RESP);
         if (aw_hs) awaddr_q <= AXI_REQ.awaddr;
         if (w_hs)
         begin
            wdata_q <= AXI_REQ.wdata;
            wstrb_q <= AXI_REQ.wstrb;
         end
         if (wr_fire)
            bresp_q <= (awaddr_q == ADDR_IRQ_CTRL || awaddr_q == ADDR_EVT_STAT ||
                        awaddr_q == ADDR_FC_COUNT || awaddr_q == ADDR_RX_COUNT)
                       ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (AXI_REQ.araddr)
         ADDR_IRQ_CTRL: rd_mux[2:0] = ctrl_q;
         ADDR_EVT_STAT:
         begin
            rd_mux[ST_LSB +: NUM_EVT] = status_q;
            rd_mux[EN_LSB +: NUM_EVT] = enable_q;
         end
         ADDR_FC_COUNT: rd_mux[7:0] = fc_q;
         ADDR_RX_COUNT: rd_mux[7:0] = rx_q;
         default:       rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         rd_state_q <= RD_IDLE;
         ar_ready_q <= 1'b0;
         rvalid_q   <= 1'b0;
         rdata_q    <= 32'h0000_0000;
         rresp_q    <= RESP_OKAY;
      end
      else
      begin
         rd_state_q <= rd_state_d;
         ar_ready_q <= (rd_state_d == RD_IDLE);
         rvalid_q   <= (rd_state_d == RD_RESP);
         if (rd_fire)
         begin
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign AXI_RSP = '{awready: aw_ready_q, wready: w_ready_q, bvalid: bvalid_q,
                      bresp: bresp_q, arready: ar_ready_q, rvalid: rvalid_q,
                      rdata: rdata_q, rresp: rresp_q};

   // read side effects land on the same edge that takes the address
   assign event_status_and_enable_clr = rd_fire && (AXI_REQ.araddr == ADDR_EVT_STAT);
   assign fc_clr   = rd_fire && (AXI_REQ.araddr == ADDR_FC_COUNT);
   assign rx_clr   = rd_fire && (AXI_REQ.araddr == ADDR_RX_COUNT);

   // ****************************************
   // control and enable registers
   // ****************************************
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         ctrl_q   <= RST_CTRL;
         enable_q <= RST_ENABLE;
      end
      else
      begin
         if (wr_lane0 && awaddr_q == ADDR_IRQ_CTRL)
            ctrl_q <= wdata_q[2:0];
         if (wr_lane0 && awaddr_q == ADDR_EVT_STAT)
            enable_q <= wdata_q[EN_LSB +: NUM_EVT];
      end
   end

   // ****************************************
   // error counters
   // ****************************************
   assign fc_inc  = PHY_EVT.false_carrier;
   // one count per carrier, none while colliding
   assign rx_inc  = PHY_EVT.carrier_valid && PHY_EVT.symbol_invalid &&
                    !PHY_EVT.collision && !counted_q;
   // half-full only on the step from 7Fh, so a read-clear cannot retrigger it
   assign fc_half = fc_inc && !fc_clr && (fc_q == CNT_BELOW_HALF);
   assign rx_half = rx_inc && !rx_clr && (rx_q == CNT_BELOW_HALF);

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         counted_q <= 1'b0;
      else if (!PHY_EVT.carrier_valid)
         counted_q <= 1'b0;
      else if (rx_inc)
         counted_q <= 1'b1;
   end

   // an event in the read cycle is kept as the first count
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         fc_q <= RST_COUNT;
      else if (fc_clr)
         fc_q <= {7'h00, fc_inc};
      else if (fc_inc && fc_q != CNT_MAX)
         fc_q <= fc_q + 8'h01;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         rx_q <= RST_COUNT;
      else if (rx_clr)
         rx_q <= {7'h00, rx_inc};
      else if (rx_inc && rx_q != CNT_MAX)
         rx_q <= rx_q + 8'h01;
   end

   // ****************************************
   // event status and interrupt
   // ****************************************
   always_comb
   begin
      evt          = '0;
      evt[EV_ED]   = PHY_EVT.energy_detect;
      evt[EV_LINK] = PHY_EVT.link_change;
      evt[EV_SPD]  = PHY_EVT.speed_change;
      evt[EV_DUP]  = PHY_EVT.duplex_change;
      evt[EV_ANC]  = PHY_EVT.autoneg_done;
      evt[EV_FHF]  = fc_half;
      evt[EV_RHF]  = rx_half;
   end

   // set beats the read-clear; enables play no part here
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         status_q <= RST_STATUS;
      else
         status_q <= (event_status_and_enable_clr ? RST_STATUS : status_q) | evt;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         irq_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else
      begin
         irq_q <= ctrl_q[CTL_TEST_BIT] ||
                  (ctrl_q[CTL_GATE_BIT] && |(status_q & enable_q));
         oe_q  <= ctrl_q[CTL_OE_BIT];
      end
   end

   // power-down level is only meaningful while the pin is an input
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         pd_meta_q <= 1'b0;
         pd_sync_q <= 1'b0;
         pd_q      <= 1'b0;
      end
      else
      begin
         pd_meta_q <= PWRDN_IRQ_I;
         pd_sync_q <= pd_meta_q;
         pd_q      <= pd_sync_q && !ctrl_q[CTL_OE_BIT];
      end
   end

   assign PWRDN_IRQ_O  = irq_q;
   assign PWRDN_IRQ_OE = oe_q;
   assign POWER_DOWN   = pd_q;

   // ****************************************
   // checks
   // ****************************************
   sequence fc_cross_s;
      fc_inc && !fc_clr && fc_q == CNT_BELOW_HALF;
   endsequence
   sequence status_read_s;
      event_status_and_enable_clr && evt == '0;
   endsequence

   a_status_sets: assert property (|evt |=> (status_q & $past(evt)) == $past(evt))
      else $error("event did not set status");
   a_irq_gated: assert property ((!ctrl_q[CTL_TEST_BIT] && !ctrl_q[CTL_GATE_BIT]) |=> !irq_q)
      else $error("irq raised while gated off");
   a_status_no_en: assert property (enable_q == '0 && |evt |=> |status_q)
      else $error("status ignored while disabled");
   a_status_clear: assert property (status_read_s |=> status_q == RST_STATUS)
      else $error("status not cleared by read");
   a_fc_half: assert property (fc_cross_s |=> status_q[EV_FHF] ##0 fc_q[CNT_HALF_BIT])
      else $error("half-full event missed");
   // counters legitimately show bit 7, so only the status word has it reserved
   a_reserved_zero: assert property (rd_fire |=> rdata_q[31:15] == '0 &&
                                     ($past(event_status_and_enable_clr) ? !rdata_q[7] : rdata_q[14:8] == '0))
      else $error("reserved bits read nonzero");
   a_fc_step: assert property (fc_inc && !fc_clr && fc_q != CNT_MAX |=> fc_q == 8'($past(fc_q) + 8'h01))
      else $error("false carrier count missed");
   a_fc_stick: assert property (fc_q == CNT_MAX && !fc_clr |=> fc_q == CNT_MAX)
      else $error("false carrier counter wrapped");
   a_rx_once: assert property (counted_q && PHY_EVT.carrier_valid && !rx_clr |=> rx_q == $past(rx_q))
      else $error("rx error counted twice in carrier");
   a_rx_collide: assert property (PHY_EVT.collision && !rx_clr |=> rx_q == $past(rx_q))
      else $error("rx error counted in collision");
   a_rx_stick: assert property (rx_q == CNT_MAX && !rx_clr |=> rx_q == CNT_MAX)
      else $error("rx error counter wrapped");
   a_pin_oe: assert property ($rose(ctrl_q[CTL_OE_BIT]) |=> PWRDN_IRQ_OE)
      else $error("pin not switched to irq output");
   a_test_irq: assert property (ctrl_q[CTL_TEST_BIT] [*2] |=> PWRDN_IRQ_O)
      else $error("test interrupt not held");
   a_irq_pending: assert property (ctrl_q[CTL_GATE_BIT] && |(status_q & enable_q) |=> irq_q)
      else $error("pending enabled event without irq");

endmodule // phy_event_status_and_error_counters

// ==== tb/axil_host.sv ====
// Purpose: register bus master standing in for the management host
// Assumes: one write and one read under way at most
// Notes:   each wait ends only on the slave's answer or the bench timeout
`timescale 1ns/1ns
module axil_host
   import phy_evt_pkg::*;
(
   input  wire logic                   clk,
   input  wire phy_evt_pkg::axil_rsp_t rsp,
   output      phy_evt_pkg::axil_req_t req
);
   initial req = '0;

   // address and data offered together, each dropped on its own ready
   task automatic write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req.awaddr  <= a;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      fork
         begin
            do @(posedge clk); while (!rsp.awready);
            req.awvalid <= 1'b0;
         end
         begin
            do @(posedge clk); while (!rsp.wready);
            req.wvalid <= 1'b0;
         end
      join
      do @(posedge clk); while (!rsp.bvalid);
      req.bready <= 1'b0;
   endtask

   task automatic read(input logic [7:0] a);
      @(posedge clk);
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      do @(posedge clk); while (!rsp.arready);
      req.arvalid <= 1'b0;
      do @(posedge clk); while (!rsp.rvalid);
      req.rready <= 1'b0;
   endtask
endmodule // axil_host

// ==== tb/phy_event_status_and_error_counters_tb.sv ====
// Purpose: self-checking bench for event status and error counters
// Assumes: host model drives the register bus, bench drives phy events
// Notes:   read results are noted in a queue and compared by a monitor
`timescale 1ns/1ns
module phy_event_status_and_error_counters_tb;
   import phy_evt_pkg::*;

   logic        SYS_CLK;
   logic        SRST;
   axil_req_t   axi_req;
   axil_rsp_t   axi_rsp;
   phy_evt_t    phy_evt;
   logic        pin_ext;
   logic        pin_w;
   logic        irq_o;
   logic        irq_oe;
   logic        pwr_dn;
   logic [33:0] exp_q[$];
   logic [1:0]  exp_b[$];
   int          fail_count;
   int          n_checks;
   int          n;

   // ****************************************
   // harness
   // ****************************************
   // shared pin: device output wins while enabled, else the board level
   assign pin_w = irq_oe ? irq_o : pin_ext;

   initial
   begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end

   axil_host u_axil_host (.clk(SYS_CLK), .rsp(axi_rsp), .req(axi_req));

   phy_event_status_and_error_counters u_phy_event_status_and_error_counters (
      .SYS_CLK      (SYS_CLK),
      .SRST         (SRST),
      .AXI_REQ      (axi_req),
      .AXI_RSP      (axi_rsp),
      .PHY_EVT      (phy_evt),
      .PWRDN_IRQ_I  (pin_w),
      .PWRDN_IRQ_O  (irq_o),
      .PWRDN_IRQ_OE (irq_oe),
      .POWER_DOWN   (pwr_dn)
   );

   // ****************************************
   // checking
   // ****************************************
   task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // oldest note is matched against each read handshake
   always @(posedge SYS_CLK)
   begin
      if (axi_rsp.rvalid && axi_req.rready)
         check("read", {axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front());
      if (axi_rsp.bvalid && axi_req.bready)
         check("bresp", {32'h0, axi_rsp.bresp}, {32'h0, exp_b.pop_front()});
   end

   function automatic logic [33:0] ok(input logic [15:0] d);
      return {RESP_OKAY, 16'h0000, d};
   endfunction

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      u_axil_host.read(a);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      exp_b.push_back(e);
      u_axil_host.write(a, d);
   endtask

   // ****************************************
   // stimulus
   // ****************************************
   // bit 8 of the event carrier is energy detect, counting downwards
   task automatic pulse(input int i, input int cnt);
      @(posedge SYS_CLK);
      phy_evt[8-i] <= 1'b1;
      repeat (cnt) @(posedge SYS_CLK);
      phy_evt[8-i] <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
   endtask

   // several bad symbols inside one carrier, optionally under collision
   task automatic rx_burst(input logic col);
      @(posedge SYS_CLK);
      phy_evt.carrier_valid  <= 1'b1;
      phy_evt.symbol_invalid <= 1'b1;
      phy_evt.collision      <= col;
      repeat (3) @(posedge SYS_CLK);
      phy_evt <= '0;
      repeat (2) @(posedge SYS_CLK);
   endtask

   task automatic irq_is(input logic e);
      repeat (4) @(posedge SYS_CLK);
      check("irq", {33'h0, irq_o}, {33'h0, e});
   endtask

   initial
   begin
      repeat (20000) @(posedge SYS_CLK);
      fail_count++;
      close_out();
   end

   initial
   begin
      fail_count = 0;
      n_checks   = 0;
      SRST       = 1'b1;
      phy_evt    = '0;
      pin_ext    = 1'b0;
      void'($urandom(78));
      repeat (5) @(posedge SYS_CLK);
      SRST <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      rd(ADDR_IRQ_CTRL, ok(0));
      rd(ADDR_EVT_STAT, ok(0));
      rd(ADDR_FC_COUNT, ok(0));
      rd(ADDR_RX_COUNT, ok(0));
      rd(8'h00, {RESP_SLVERR, 32'h0});
      wr(8'h00, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(ADDR_EVT_STAT, 32'hFFFF_FFFF, RESP_OKAY);
      rd(ADDR_EVT_STAT, ok(16'h007F));
      wr(ADDR_FC_COUNT, 32'hFFFF_FFFF, RESP_OKAY);
      wr(ADDR_RX_COUNT, 32'hFFFF_FFFF, RESP_OKAY);
      rd(ADDR_FC_COUNT, ok(0));
      rd(ADDR_RX_COUNT, ok(0));
      // status sets with every enable clear, then clears on read
      wr(ADDR_EVT_STAT, 32'h0000_0000, RESP_OKAY);
      for (int i = 0; i < 5; i++)
      begin
         pulse(i, 1);
         rd(ADDR_EVT_STAT, ok(16'(1 << (14 - i))));
         rd(ADDR_EVT_STAT, ok(0));
      end
      // outside test mode, interrupt needs both event enable and global gate
      wr(ADDR_EVT_STAT, 32'h0000_0040, RESP_OKAY);
      wr(ADDR_IRQ_CTRL, 32'h0000_0002, RESP_OKAY);
      pulse(0, 1);
      irq_is(1'b1);
      rd(ADDR_EVT_STAT, ok(16'h4040));
      irq_is(1'b0);
      wr(ADDR_IRQ_CTRL, 32'h0000_0000, RESP_OKAY);
      pulse(0, 1);
      irq_is(1'b0);
      rd(ADDR_EVT_STAT, ok(16'h4040));
      wr(ADDR_IRQ_CTRL, 32'h0000_0004, RESP_OKAY);
      irq_is(1'b1);
      irq_is(1'b1);
      check("oe", {33'h0, irq_oe}, 34'h0);
      // pin reads as power-down input until switched to an output
      pin_ext <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      check("pwrdn", {33'h0, pwr_dn}, 34'h1);
      wr(ADDR_IRQ_CTRL, 32'h0000_0001, RESP_OKAY);
      irq_is(1'b0);
      check("oe", {33'h0, irq_oe}, 34'h1);
      check("pwrdn", {33'h0, pwr_dn}, 34'h0);
      // false carrier counts, half-full event, saturation
      n = $urandom_range(1, 100);
      pulse(5, n);
      rd(ADDR_FC_COUNT, ok(16'(n)));
      pulse(5, 128);
      rd(ADDR_FC_COUNT, ok(16'h0080));
      rd(ADDR_EVT_STAT, ok(16'h0240));
      pulse(5, 300);
      rd(ADDR_FC_COUNT, ok(16'h00FF));
      rd(ADDR_FC_COUNT, ok(0));
      // receive errors: once per carrier, none under collision
      rx_burst(1'b0);
      rx_burst(1'b1);
      rd(ADDR_RX_COUNT, ok(16'h0001));
      repeat (128) rx_burst(1'b0);
      rd(ADDR_RX_COUNT, ok(16'h0080));
      // false carrier crossed half again while saturating, still pending
      rd(ADDR_EVT_STAT, ok(16'h0340));
      repeat (260) rx_burst(1'b0);
      rd(ADDR_RX_COUNT, ok(16'h00FF));
      repeat (4) @(posedge SYS_CLK);
      close_out();
   end
endmodule // phy_event_status_and_error_counters_tb
